// ===== core/ddoc_top.v
// DIMM kind and DRAM option configuration register with init capture and parity
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/10ps
`include "ddoc_map.vh"
module ddoc_top #(
  parameter       KIND_WRITABLE = 1,
  parameter [0:0] KIND_RESET    = 1'b1
) (
  input  wire                        core_clk_i,
  input  wire                        resetn_i,
  input  wire [`DDOC_ADDR_W-1:0]     reg_addr_i,
  input  wire [31:0]                 reg_wdata_i,
  input  wire                        reg_wr_i,
  input  wire                        reg_rd_i,
  output reg  [31:0]                 reg_rdata_o,
  input  wire [`DDOC_ADDR_CMD_W-1:0] addr_cmd_i,
  input  wire                        par_err_n_i,
  output wire                        addr_parity_out_o,
  output reg                         irq_o,
  output reg                         dimm_kind_plain_o,
  output reg  [3:0]                  narrow_device_flags_o,
  output reg                         dual_module_width_o,
  output reg  [3:0]                  burst_beats_o,
  output reg  [6:0]                  access_bytes_o,
  output reg                         init_busy_o,
  output reg  [15:0]                 emrs1_o,
  output reg  [15:0]                 emrs2_o
);
  reg        rst_meta;
  reg        rst_sync;
  reg [31:0] cfg_low;
  reg        gen3_mode_select;
  reg [`DDOC_ST_W-1:0] status;
  reg [`DDOC_ST_W-1:0] irq_mask;
  reg        err_meta;
  reg        err_sync;
  reg [9:0]  init_cnt;
  reg        init_busy;
  wire       wr_cfg;
  wire       init_cmd;
  wire [31:0] next_cfg_low;
  wire       par_err_evt;
  wire       init_done_evt;
  wire       illegal_evt;
  reg  [`DDOC_ST_W-1:0] next_status;
  reg  [31:0] next_rdata;
  wire       next_init_busy;
  wire [3:0] next_narrow;

  // Reset image carries the product strap for the kind bit
  localparam [9:0]  INIT_CYC_V    = `DDOC_INIT_CYC;
  localparam [31:0] CFG_LOW_RST_V = `DDOC_CFG_LOW_RST
                                    | ({31'h0, KIND_RESET} << `DDOC_BIT_KIND);

  // Merge writable bits; kind bit writable only when the product allows it
  function [31:0] ddoc_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    begin
      ddoc_merge = (old_v & ~`DDOC_CFG_LOW_WMASK) | (new_v & `DDOC_CFG_LOW_WMASK);
      if (KIND_WRITABLE != 0) begin
        ddoc_merge[`DDOC_BIT_KIND] = new_v[`DDOC_BIT_KIND];
      end
    end
  endfunction

  // Both bits set together is the unsupported combination
  function ddoc_illegal;
    input [31:0] v;
    begin
      ddoc_illegal = v[`DDOC_BIT_HALF_BURST] & v[`DDOC_BIT_DUAL_W];
    end
  endfunction

  // Beats per access; width takes priority, half bursts mean nothing in gen3
  function [3:0] ddoc_beats;
    input [31:0] v;
    input        gen3;
    begin
      if (v[`DDOC_BIT_DUAL_W]) begin
        ddoc_beats = 4'h4;
      end else if (v[`DDOC_BIT_HALF_BURST] && !gen3) begin
        ddoc_beats = 4'h4;
      end else begin
        ddoc_beats = 4'h8;
      end
    end
  endfunction

  // Bytes per access: 32 only for half bursts on a single module width
  function [6:0] ddoc_bytes;
    input [31:0] v;
    input        gen3;
    begin
      if (v[`DDOC_BIT_HALF_BURST] && !v[`DDOC_BIT_DUAL_W] && !gen3) begin
        ddoc_bytes = 7'h20;
      end else begin
        ddoc_bytes = 7'h40;
      end
    end
  endfunction

  // Reset release is synchronised; assertion stays asynchronous
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  assign wr_cfg       = reg_wr_i & (reg_addr_i == `DDOC_OFF_CFG_LOW);
  assign init_cmd     = wr_cfg & reg_wdata_i[`DDOC_BIT_INIT];
  assign next_cfg_low = wr_cfg ? ddoc_merge(cfg_low, reg_wdata_i) : cfg_low;
  assign illegal_evt  = wr_cfg & ddoc_illegal(reg_wdata_i);
  // Parity errors only matter with parity on and registered DIMMs
  assign par_err_evt  = cfg_low[`DDOC_BIT_PAR_EN] & ~cfg_low[`DDOC_BIT_KIND]
                        & ~err_sync;
  assign init_done_evt = init_busy & (init_cnt == 10'h001);

  // Busy output tracks the timer exactly, falling with the last counted cycle
  assign next_init_busy = (init_cmd && !init_busy) ? 1'b1 :
                          init_busy ? (init_cnt != 10'h001) :
                          1'b0;

  // One x4 flag per logical DIMM, DIMM 0 in the lowest position
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_narrow
      assign next_narrow[gi] = next_cfg_low[`DDOC_BIT_NARROW_LO + gi];
    end
  endgenerate

  always @(posedge core_clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      cfg_low <= CFG_LOW_RST_V;
    end else if (!rst_meta) begin
      cfg_low <= CFG_LOW_RST_V;
    end else begin
      cfg_low <= next_cfg_low;
    end
  end

  always @(posedge core_clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      gen3_mode_select <= 1'b0;
      irq_mask         <= {`DDOC_ST_W{1'b0}};
    end else if (reg_wr_i) begin
      if (reg_addr_i == `DDOC_OFF_CFG_HIGH) begin
        gen3_mode_select <= reg_wdata_i[`DDOC_BIT_GEN3];
      end
      if (reg_addr_i == `DDOC_OFF_IRQ_MASK) begin
        irq_mask <= reg_wdata_i[`DDOC_ST_W-1:0];
      end
    end
  end

  // Error pin is read only through the second flop
  always @(posedge core_clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      err_meta <= 1'b1;
      err_sync <= 1'b1;
    end else begin
      err_meta <= par_err_n_i;
      err_sync <= err_meta;
    end
  end

  // Init sequence timer; the captured fields come from this write
  always @(posedge core_clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      init_busy <= 1'b0;
      init_cnt  <= 10'h000;
    end else if (init_cmd && !init_busy) begin
      init_busy <= 1'b1;
      init_cnt  <= INIT_CYC_V;
    end else if (init_busy) begin
      init_cnt  <= init_cnt - 10'h001;
      if (init_cnt == 10'h001) begin
        init_busy <= 1'b0;
      end
    end
  end

  // Sticky status: set wins over write-one-to-clear
  always @* begin
    next_status = status;
    if (reg_wr_i && (reg_addr_i == `DDOC_OFF_STATUS)) begin
      next_status = status & ~reg_wdata_i[`DDOC_ST_W-1:0];
    end
    if (par_err_evt) begin
      next_status[`DDOC_ST_PAR_ERR] = 1'b1;
    end
    if (init_done_evt) begin
      next_status[`DDOC_ST_INIT_DONE] = 1'b1;
    end
    if (illegal_evt) begin
      next_status[`DDOC_ST_ILLEGAL] = 1'b1;
    end
  end

  always @(posedge core_clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      status <= {`DDOC_ST_W{1'b0}};
      irq_o  <= 1'b0;
    end else begin
      status <= next_status;
      irq_o  <= |(next_status & irq_mask);
    end
  end

  // Unmapped offsets read as zero
  always @* begin
    next_rdata = 32'h0000_0000;
    case (reg_addr_i)
      `DDOC_OFF_CFG_LOW: begin
        next_rdata = {cfg_low[31:1], init_busy};
      end
      `DDOC_OFF_CFG_HIGH: begin
        next_rdata[`DDOC_BIT_GEN3] = gen3_mode_select;
      end
      `DDOC_OFF_STATUS: begin
        next_rdata[`DDOC_ST_W-1:0] = status;
      end
      `DDOC_OFF_IRQ_MASK: begin
        next_rdata[`DDOC_ST_W-1:0] = irq_mask;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge core_clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  // Decoded configuration outputs, refreshed from the latest value
  always @(posedge core_clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      dimm_kind_plain_o     <= KIND_RESET;
      narrow_device_flags_o <= 4'h0;
      dual_module_width_o   <= 1'b0;
      burst_beats_o         <= 4'h8;
      access_bytes_o        <= 7'h40;
      init_busy_o           <= 1'b0;
      emrs1_o               <= 16'h0000;
      emrs2_o               <= 16'h0000;
    end else begin
      dimm_kind_plain_o     <= next_cfg_low[`DDOC_BIT_KIND];
      narrow_device_flags_o <= next_narrow;
      dual_module_width_o   <= next_cfg_low[`DDOC_BIT_DUAL_W];
      init_busy_o           <= next_init_busy;
      // Burst shape follows the latest width, burst and generation settings
      burst_beats_o         <= ddoc_beats(next_cfg_low, gen3_mode_select);
      access_bytes_o        <= ddoc_bytes(next_cfg_low, gen3_mode_select);
      // EMRS images latched at the init command from the same write, or zeroed in gen3 mode
      if (init_cmd && !init_busy) begin
        if (gen3_mode_select) begin
          emrs1_o <= 16'h0000;
          emrs2_o <= 16'h0000;
        end else begin
          emrs1_o <= {5'h00, next_cfg_low[`DDOC_BIT_COMP_DIS], 3'h0,
                      next_cfg_low[`DDOC_BIT_ODT_HI], 3'h0,
                      next_cfg_low[`DDOC_BIT_ODT_LO], 1'b0,
                      next_cfg_low[`DDOC_BIT_WEAK]};
          emrs2_o <= {8'h00, next_cfg_low[`DDOC_BIT_FAST_SR], 7'h00};
        end
      end
    end
  end

  // Parity is only driven toward registered DIMMs
  ddoc_parity i_ddoc_parity (
    .clk_i      (core_clk_i),
    .rst_n_i    (rst_sync),
    .enable_i   (cfg_low[`DDOC_BIT_PAR_EN] & ~cfg_low[`DDOC_BIT_KIND]),
    .addr_cmd_i (addr_cmd_i),
    .parity_o   (addr_parity_out_o)
  );
endmodule

// ===== include/ddoc_map.vh
// Register offsets, field positions, reset values and timing counts of the DIMM option block
`ifndef DDOC_MAP_VH
`define DDOC_MAP_VH
`define DDOC_ADDR_W         4
`define DDOC_OFF_CFG_LOW    4'h0
`define DDOC_OFF_CFG_HIGH   4'h4
`define DDOC_OFF_STATUS     4'h8
`define DDOC_OFF_IRQ_MASK   4'hc
`define DDOC_BIT_INIT       0
`define DDOC_BIT_ODT_LO     4
`define DDOC_BIT_ODT_HI     5
`define DDOC_BIT_COMP_DIS   6
`define DDOC_BIT_WEAK       7
`define DDOC_BIT_PAR_EN     8
`define DDOC_BIT_FAST_SR    9
`define DDOC_BIT_HALF_BURST 10
`define DDOC_BIT_DUAL_W     11
`define DDOC_BIT_NARROW_LO  12
`define DDOC_BIT_NARROW_HI  15
`define DDOC_BIT_KIND       16
`define DDOC_BIT_GEN3       0
`define DDOC_CFG_LOW_RST    32'h0000_0000
`define DDOC_CFG_LOW_WMASK  32'h0000_fff0
`define DDOC_ST_PAR_ERR     0
`define DDOC_ST_INIT_DONE   1
`define DDOC_ST_ILLEGAL     2
`define DDOC_ST_W           3
`define DDOC_ADDR_CMD_W     24
`define DDOC_INIT_NS        1000
`define DDOC_CLK_NS         20
`define DDOC_INIT_CYC       ((`DDOC_INIT_NS + `DDOC_CLK_NS - 1) / `DDOC_CLK_NS)
`define DDOC_ODT_OFF        2'h0
`define DDOC_ODT_75         2'h1
`define DDOC_ODT_150        2'h2
`define DDOC_ODT_50         2'h3
`endif

// ===== core/ddoc_parity.v
// Even address/command parity generator with registered output
`timescale 1ns/10ps
`include "ddoc_map.vh"
module ddoc_parity (
  input  wire                          clk_i,
  input  wire                          rst_n_i,
  input  wire                          enable_i,
  input  wire [`DDOC_ADDR_CMD_W-1:0]   addr_cmd_i,
  output reg                           parity_o
);
  // Output matches the address/command registered on the same edge
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      parity_o <= 1'b0;
    end else begin
      parity_o <= enable_i & (^addr_cmd_i);
    end
  end
endmodule

// ===== tb/ddoc_checker.sv
// Concurrent checks on the DIMM option block outputs
`timescale 1ns/10ps
`include "ddoc_map.vh"
module ddoc_checker (
  input wire                        core_clk_i,
  input wire                        resetn_i,
  input wire [`DDOC_ADDR_CMD_W-1:0] addr_cmd_i,
  input wire                        addr_parity_out_o,
  input wire                        dimm_kind_plain_o,
  input wire                        dual_module_width_o,
  input wire [3:0]                  burst_beats_o,
  input wire [6:0]                  access_bytes_o,
  input wire                        init_busy_o,
  input wire [15:0]                 emrs1_o,
  input wire [15:0]                 emrs2_o
);
  localparam int INIT = `DDOC_INIT_CYC;
  reg [7:0] busy_cnt;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // Counts the cycles of one init sequence
  always @(posedge core_clk_i or negedge resetn_i)
    if (!resetn_i)
      busy_cnt <= 8'h0;
    else
      busy_cnt <= init_busy_o ? busy_cnt + 8'h1 : 8'h0;
  property p_par_even; addr_parity_out_o |-> $past(^addr_cmd_i); endproperty
  a_par_even: assert property (p_par_even) else $error("parity bit wrong");
  property p_par_kind; dimm_kind_plain_o && $past(dimm_kind_plain_o) |-> !addr_parity_out_o;
  endproperty
  a_par_kind: assert property (p_par_kind) else $error("parity on plain dimms");
  property p_half; access_bytes_o == 7'h20 |-> burst_beats_o == 4'h4 && !dual_module_width_o;
  endproperty
  a_half: assert property (p_half) else $error("half burst decode wrong");
  property p_dual; dual_module_width_o |-> burst_beats_o == 4'h4 && access_bytes_o == 7'h40;
  endproperty
  a_dual: assert property (p_dual) else $error("dual width decode wrong");
  property p_long; burst_beats_o == 4'h8 |-> access_bytes_o == 7'h40; endproperty
  a_long: assert property (p_long) else $error("eight beat decode wrong");
  property p_init_len; $fell(init_busy_o) |-> busy_cnt == INIT; endproperty
  a_init_len: assert property (p_init_len) else $error("init length wrong");
  property p_emrs_hold; init_busy_o && $past(init_busy_o) |-> $stable(emrs1_o) && $stable(emrs2_o);
  endproperty
  a_emrs_hold: assert property (p_emrs_hold) else $error("mode image moved");
  property p_emrs1; (emrs1_o & 16'hfbba) == 16'h0; endproperty
  a_emrs1: assert property (p_emrs1) else $error("mode image 1 stray bit");
  property p_emrs2; (emrs2_o & 16'hff7f) == 16'h0; endproperty
  a_emrs2: assert property (p_emrs2) else $error("mode image 2 stray bit");
  c_init: cover property ($fell(init_busy_o));
  c_half: cover property (access_bytes_o == 7'h20);
  c_par: cover property (addr_parity_out_o);
endmodule

// ===== tb/ddoc_dimm_model.sv
// Registered DIMM model: address/command traffic and parity error line
`timescale 1ns/10ps
module ddoc_dimm_model (
  input  wire        clk_i,
  input  wire        inject_i,
  input  wire        parity_i,
  output reg  [23:0] addr_cmd_o,
  output reg         err_n_o
);
  reg [23:0] a1;
  initial begin
    addr_cmd_o = 24'h000001;
    a1 = 24'h0;
    err_n_o = 1'b1;
  end
  // Traffic changes every cycle; parity is due one edge after the command
  always @(posedge clk_i) begin
    a1 <= addr_cmd_o;
    addr_cmd_o <= addr_cmd_o * 24'h000005 + 24'h3c5a91;
    err_n_o <= ~(inject_i | (parity_i ^ (^a1)));
  end
endmodule

// ===== tb/test_ddoc_top.sv
// Self-checking testbench of the DIMM option block
`timescale 1ns/10ps
module test_ddoc_top;
  reg         core_clk_i;
  reg         resetn_i;
  reg  [3:0]  reg_addr_i;
  reg  [31:0] reg_wdata_i;
  reg         reg_wr_i;
  reg         reg_rd_i;
  reg         inject;
  wire [31:0] reg_rdata_o;
  wire [23:0] addr_cmd_i;
  wire        par_err_n_i, addr_parity_out_o, irq_o, dimm_kind_plain_o, dual_module_width_o;
  wire        init_busy_o;
  wire [3:0]  narrow_device_flags_o, burst_beats_o;
  wire [6:0]  access_bytes_o;
  wire [15:0] emrs1_o, emrs2_o;
  integer     miscompares, checked;
  reg  [2:0]  k;
  ddoc_top i_ddoc_top (.core_clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .addr_cmd_i, .par_err_n_i, .addr_parity_out_o, .irq_o, .dimm_kind_plain_o,
    .narrow_device_flags_o, .dual_module_width_o, .burst_beats_o, .access_bytes_o,
    .init_busy_o, .emrs1_o, .emrs2_o);
  ddoc_dimm_model i_ddoc_dimm_model (.clk_i(core_clk_i), .inject_i(inject),
    .parity_i(addr_parity_out_o), .addr_cmd_o(addr_cmd_i), .err_n_o(par_err_n_i));
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
    end
  endtask
  task cmp(input [31:0] g, input [31:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("Error at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task chk_rd(input [3:0] a, input [31:0] e);
    begin
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      #1 cmp(reg_rdata_o, e);
    end
  endtask
  task settle(input integer n);
    begin
      repeat (n) @(posedge core_clk_i);
      #1;
    end
  endtask
  task wait_idle;
    integer n;
    begin
      for (n = 0; n < 100 && init_busy_o !== 1'b0; n = n + 1)
        @(posedge core_clk_i);
      #1 cmp(init_busy_o, 1'b0);
    end
  endtask
  task t_fields;
    begin
      chk_rd(4'h0, 32'h0001_0000);
      cmp({dimm_kind_plain_o, burst_beats_o, access_bytes_o}, {1'b1, 4'h8, 7'h40});
      chk_rd(4'h2, 32'h0);
      wr(4'h0, 32'h0000_5af0);
      chk_rd(4'h0, 32'h0000_5af0);
      cmp({narrow_device_flags_o, dual_module_width_o, burst_beats_o}, {4'h5, 1'b1, 4'h4});
      $display("t_fields done");
    end
  endtask
  task t_burst;
    begin
      for (k = 0; k < 3; k = k + 1) begin
        wr(4'h0, {20'h0, k[1:0], 10'h0});
        settle(2);
        cmp({burst_beats_o, access_bytes_o}, {k == 0 ? 4'h8 : 4'h4, k == 1 ? 7'h20 : 7'h40});
      end
      wr(4'h0, 32'h0000_0c00);
      chk_rd(4'h8, 32'h4);
      cmp(irq_o, 1'b0);
      wr(4'hc, 32'h4);
      settle(2);
      cmp(irq_o, 1'b1);
      wr(4'h8, 32'h4);
      settle(2);
      cmp(irq_o, 1'b0);
      cmp(reg_rdata_o, 32'h0);
      $display("t_burst done");
    end
  endtask
  task t_init;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        wr(4'h0, {22'h0, k[1], 1'b0, k[0], k[1], k[1:0], 4'h1});
        #1 cmp(init_busy_o, 1'b1);
        cmp({emrs1_o, emrs2_o}, {5'h0, k[1], 3'h0, k[1], 3'h0, k[0], 1'b0, k[0],
          8'h0, k[1], 7'h0});
        chk_rd(4'h0, {22'h0, k[1], 1'b0, k[0], k[1], k[1:0], 4'h1});
        wait_idle;
        chk_rd(4'h8, 32'h2);
        wr(4'h8, 32'h2);
      end
      wr(4'h4, 32'h1);
      wr(4'h0, 32'h0000_06f1);
      #1 cmp({emrs1_o, emrs2_o}, 32'h0);
      wait_idle;
      cmp({burst_beats_o, access_bytes_o}, {4'h8, 7'h40});
      wr(4'h8, 32'h2);
      wr(4'h4, 32'h0);
      $display("t_init done");
    end
  endtask
  task t_parity;
    begin
      wr(4'h0, 32'h0000_0100);
      settle(8);
      wr(4'h8, 32'h1);
      settle(12);
      chk_rd(4'h8, 32'h0);
      @(posedge core_clk_i);
      inject <= 1'b1;
      @(posedge core_clk_i);
      inject <= 1'b0;
      settle(6);
      chk_rd(4'h8, 32'h1);
      wr(4'h8, 32'h1);
      wr(4'h0, 32'h0001_0100);
      settle(12);
      chk_rd(4'h8, 32'h0);
      cmp(addr_parity_out_o, 1'b0);
      $display("t_parity done");
    end
  endtask
  task complete_run;
    begin
      $display("Checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    #200000;
    miscompares = miscompares + 1;
    complete_run;
  end
  initial begin
    miscompares = 0;
    checked = 0;
    resetn_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 32'h0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    inject = 1'b0;
    repeat (8) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    t_fields;
    t_burst;
    t_init;
    t_parity;
    complete_run;
  end
endmodule
bind ddoc_top ddoc_checker i_ddoc_checker (.core_clk_i, .resetn_i, .addr_cmd_i, .addr_parity_out_o,
  .dimm_kind_plain_o, .dual_module_width_o, .burst_beats_o, .access_bytes_o, .init_busy_o,
  .emrs1_o, .emrs2_o);
